/* File: logic/pssw_top.sv */
// Our own choice: the APB register port.
`include "pssw_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module pssw_top #(
  parameter int unsigned HOLD_UNIT_CYCLES = `PSSW_HOLD_UNIT_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = `PSSW_DEBOUNCE_CYC,
  parameter logic [15:0] USER_KEY = 16'h5ac3 // Arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pssw_pkg::pssw_ps_e ps_state,
  input wire logic por_ind,
  input wire logic switch_n,
  output pssw_pkg::pssw_req_s sw_req,
  output logic on_state_ind,
  output logic sleep_state_ind,
  output logic power_state_primary_irq,
  output logic switch_primary_irq,
  output logic irq
);
  import pssw_pkg::*;
  // ****************************************
  // Parameter checks and decoding
  // ****************************************
  if (HOLD_UNIT_CYCLES < 1 || HOLD_UNIT_CYCLES > 32'h1fff_ffff) begin
    $error("HOLD_UNIT_CYCLES out of range");
  end
  if (DEBOUNCE_CYCLES < 1) begin
    $error("DEBOUNCE_CYCLES must be at least one");
  end
  function automatic pssw_reg_e decode(input logic [31:0] a);
    pssw_reg_e r;
    r = PSSW_R_NONE;
    if (a[31:18] == 14'h0 && a[1:0] == 2'h0) begin
      unique case (a[17:2])
        `PSSW_IDX_SW_CTRL: r = PSSW_R_CTRL;
        `PSSW_IDX_SEC_KEY: r = PSSW_R_KEY;
        `PSSW_IDX_OFF_SRC: r = PSSW_R_OFFSRC;
        `PSSW_IDX_INT_STS1: r = PSSW_R_STS1;
        `PSSW_IDX_INT_STS2: r = PSSW_R_STS2;
        `PSSW_IDX_INT_MSK1: r = PSSW_R_MSK1;
        `PSSW_IDX_INT_MSK2: r = PSSW_R_MSK2;
        default: r = PSSW_R_NONE;
      endcase
    end
    return r;
  endfunction
  function automatic logic [31:0] hold_limit(input logic [1:0] to);
    return HOLD_UNIT_CYCLES << to;
  endfunction
  // ****************************************
  // APB slave
  // ****************************************
  pssw_reg_e sel_reg;
  logic wr_en;
  logic [31:0] rd_nxt;
  assign sel_reg = decode(paddr);
  assign wr_en = psel & penable & pwrite & pready;
  pssw_cfg_s cfg_r;
  logic key_ok_r;
  logic off_src_sw_r;
  logic sw_flag_r;
  logic [2:0] ps_flags_r;
  logic sw_mask_r;
  logic [2:0] ps_mask_r;
  logic sw_raw_r;
  always_comb begin
    rd_nxt = 32'h0;
    unique case (sel_reg)
      PSSW_R_CTRL: begin
        rd_nxt[`PSSW_SECACT_LSB +: 2] = cfg_r.sec_act;
        rd_nxt[`PSSW_PRIMACT_LSB +: 2] = cfg_r.prim_act;
        rd_nxt[`PSSW_STS_BIT] = sw_raw_r;
        rd_nxt[`PSSW_TO_LSB +: 2] = cfg_r.hold_to;
      end
      PSSW_R_KEY: rd_nxt[0] = key_ok_r;
      PSSW_R_OFFSRC: rd_nxt[`PSSW_OFFSRC_SW_BIT] = off_src_sw_r;
      PSSW_R_STS1: rd_nxt[`PSSW_SW_FLAG_BIT] = sw_flag_r;
      PSSW_R_STS2: rd_nxt[2:0] = ps_flags_r;
      PSSW_R_MSK1: rd_nxt[`PSSW_SW_FLAG_BIT] = sw_mask_r;
      PSSW_R_MSK2: rd_nxt[2:0] = ps_mask_r;
      PSSW_R_NONE: rd_nxt = 32'h0;
    endcase
  end

  // One wait state: data and ready are both registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata <= pwrite ? 32'h0 : rd_nxt;
        pslverr <= (sel_reg == PSSW_R_NONE);
      end else begin
        pslverr <= 1'b0;
      end
    end
  end
  // ****************************************
  // Security key and configuration
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_ok_r <= 1'b0;
    end else if (wr_en && sel_reg == PSSW_R_KEY) begin
      key_ok_r <= (pwdata[15:0] == USER_KEY);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r.sec_act <= `PSSW_SECACT_RST;
      cfg_r.prim_act <= `PSSW_PRIMACT_RST;
      cfg_r.hold_to <= `PSSW_TO_RST;
    end else if (wr_en && sel_reg == PSSW_R_CTRL && key_ok_r) begin
      cfg_r.sec_act <= pwdata[`PSSW_SECACT_LSB +: 2];
      cfg_r.prim_act <= pwdata[`PSSW_PRIMACT_LSB +: 2];
      cfg_r.hold_to <= pwdata[`PSSW_TO_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_mask_r <= `PSSW_MASK_RST;
      ps_mask_r <= {3{`PSSW_MASK_RST}};
    end else if (wr_en) begin
      if (sel_reg == PSSW_R_MSK1) begin
        sw_mask_r <= pwdata[`PSSW_SW_FLAG_BIT];
      end
      if (sel_reg == PSSW_R_MSK2) begin
        ps_mask_r <= pwdata[2:0];
      end
    end
  end
  // ****************************************
  // Power-state events
  // ****************************************
  pssw_ps_e ps_prev_r;
  logic por_prev_r;
  logic [2:0] ps_set;
  logic [2:0] ps_clr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_prev_r <= PSSW_PS_OFF;
      por_prev_r <= 1'b0;
    end else begin
      ps_prev_r <= ps_state;
      por_prev_r <= por_ind;
    end
  end

  always_comb begin
    ps_set = 3'h0;
    ps_set[`PSSW_POR_BIT] = por_ind & ~por_prev_r;
    ps_set[`PSSW_SLPOFF_BIT] = (ps_state == PSSW_PS_SLEEP ||
        ps_state == PSSW_PS_OFF) && ps_state != ps_prev_r;
    ps_set[`PSSW_ONWAKE_BIT] = ps_state == PSSW_PS_ON &&
        ps_prev_r != PSSW_PS_ON;
    ps_clr = (wr_en && sel_reg == PSSW_R_STS2) ? pwdata[2:0] : 3'h0;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_flags_r <= 3'h0;
    end else begin
      ps_flags_r <= (ps_flags_r & ~ps_clr) | ps_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_state_ind <= 1'b0;
      sleep_state_ind <= 1'b0;
    end else begin
      on_state_ind <= (ps_state == PSSW_PS_ON);
      sleep_state_ind <= (ps_state == PSSW_PS_SLEEP);
    end
  end
  // ****************************************
  // Switch debounce
  // ****************************************
  logic sw_deb_r;
  logic [31:0] deb_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_raw_r <= 1'b1;
    end else begin
      sw_raw_r <= switch_n;
    end
  end

  // Level must hold steady for the full window before it is accepted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_deb_r <= 1'b1;
      deb_cnt_r <= 32'h0;
    end else if (sw_raw_r == sw_deb_r) begin
      deb_cnt_r <= 32'h0;
    end else if (deb_cnt_r >= DEBOUNCE_CYCLES - 1) begin
      sw_deb_r <= sw_raw_r;
      deb_cnt_r <= 32'h0;
    end else begin
      deb_cnt_r <= deb_cnt_r + 32'h1;
    end
  end

  logic sw_deb_prev_r;
  logic press;
  logic release_ev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_deb_prev_r <= 1'b1;
    end else begin
      sw_deb_prev_r <= sw_deb_r;
    end
  end

  assign press = sw_deb_prev_r & ~sw_deb_r;
  assign release_ev = ~sw_deb_prev_r & sw_deb_r;
  // ****************************************
  // Hold timer and actions
  // ****************************************
  typedef enum logic [1:0] {
    PSSW_HS_IDLE,
    PSSW_HS_SEC,
    PSSW_HS_TER,
    PSSW_HS_DONE
  } pssw_hs_e;
  pssw_hs_e hs_r;
  logic [31:0] hold_cnt_r;
  logic expire;
  logic sec_fire;
  logic ter_fire;
  assign expire = hold_cnt_r >= hold_limit(cfg_r.hold_to) - 32'h1;
  assign sec_fire = hs_r == PSSW_HS_SEC && expire && !release_ev;
  assign ter_fire = hs_r == PSSW_HS_TER && expire && !release_ev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_r <= PSSW_HS_IDLE;
      hold_cnt_r <= 32'h0;
    end else if (release_ev) begin
      hs_r <= PSSW_HS_IDLE;
      hold_cnt_r <= 32'h0;
    end else if (press) begin
      hs_r <= PSSW_HS_SEC;
      hold_cnt_r <= 32'h0;
    end else begin
      unique case (hs_r)
        PSSW_HS_IDLE, PSSW_HS_DONE: hold_cnt_r <= 32'h0;
        PSSW_HS_SEC: begin
          if (expire) begin
            hs_r <= PSSW_HS_TER;
            hold_cnt_r <= 32'h0;
          end else begin
            hold_cnt_r <= hold_cnt_r + 32'h1;
          end
        end
        PSSW_HS_TER: begin
          if (expire) begin
            hs_r <= PSSW_HS_DONE;
            hold_cnt_r <= 32'h0;
          end else begin
            hold_cnt_r <= hold_cnt_r + 32'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_req <= '0;
    end else begin
      sw_req.on_req <= (press && cfg_r.prim_act == `PSSW_PRI_ON) ||
          (sec_fire && cfg_r.sec_act == `PSSW_SEC_ON);
      sw_req.off_req <= (press && cfg_r.prim_act == `PSSW_PRI_OFF) ||
          (sec_fire && cfg_r.sec_act == `PSSW_SEC_OFF) ||
          ter_fire;
    end
  end
  // ****************************************
  // Switch flag and off-source record
  // ****************************************
  logic sw_set;
  logic sw_clr;
  assign sw_set = press | release_ev |
      (sec_fire && cfg_r.sec_act == `PSSW_SEC_IRQ);
  assign sw_clr = wr_en && sel_reg == PSSW_R_STS1 &&
      pwdata[`PSSW_SW_FLAG_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_flag_r <= 1'b0;
    end else begin
      sw_flag_r <= (sw_flag_r & ~sw_clr) | sw_set;
    end
  end

  logic sw_off_pend_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_off_pend_r <= 1'b0;
      off_src_sw_r <= 1'b0;
    end else begin
      if (sw_req.off_req) begin
        sw_off_pend_r <= 1'b1;
      end else if (ps_state != ps_prev_r) begin
        sw_off_pend_r <= 1'b0;
      end
      if (ps_state == PSSW_PS_OFF && ps_prev_r != PSSW_PS_OFF) begin
        off_src_sw_r <= sw_off_pend_r | sw_req.off_req;
      end
    end
  end
  // ****************************************
  // Interrupt outputs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_state_primary_irq <= 1'b0;
      switch_primary_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      power_state_primary_irq <= |(ps_flags_r & ~ps_mask_r);
      switch_primary_irq <= sw_flag_r & ~sw_mask_r;
      irq <= |(ps_flags_r & ~ps_mask_r) | (sw_flag_r & ~sw_mask_r);
    end
  end

endmodule

`default_nettype wire

/* File: logic/pssw_regs.svh */
`ifndef PSSW_REGS_SVH
`define PSSW_REGS_SVH

// Register indices; the byte address is four times the index
`define PSSW_IDX_SW_CTRL 16'h4005
`define PSSW_IDX_SEC_KEY 16'h4008
`define PSSW_IDX_OFF_SRC 16'h4009
`define PSSW_IDX_INT_STS1 16'h4011
`define PSSW_IDX_INT_STS2 16'h4012
`define PSSW_IDX_INT_MSK1 16'h4019
`define PSSW_IDX_INT_MSK2 16'h401a

// Field positions
`define PSSW_SECACT_LSB 8
`define PSSW_PRIMACT_LSB 4
`define PSSW_STS_BIT 3
`define PSSW_TO_LSB 0
`define PSSW_SW_FLAG_BIT 12
`define PSSW_POR_BIT 2
`define PSSW_SLPOFF_BIT 1
`define PSSW_ONWAKE_BIT 0
`define PSSW_OFFSRC_SW_BIT 4

// Reset values
`define PSSW_SECACT_RST 2'h1
`define PSSW_PRIMACT_RST 2'h0
`define PSSW_TO_RST 2'h0
`define PSSW_MASK_RST 1'b1

// Action encodings
`define PSSW_PRI_ON 2'h1
`define PSSW_PRI_OFF 2'h2
`define PSSW_SEC_IRQ 2'h0
`define PSSW_SEC_ON 2'h1
`define PSSW_SEC_OFF 2'h2

// Timing
`define PSSW_CLK_HZ 100000000
`define PSSW_HOLD_UNIT_S 1
`define PSSW_HOLD_UNIT_CYC (`PSSW_CLK_HZ * `PSSW_HOLD_UNIT_S)
`define PSSW_DEBOUNCE_MS 20
`define PSSW_DEBOUNCE_CYC (`PSSW_CLK_HZ / 1000 * `PSSW_DEBOUNCE_MS)

`endif

/* File: logic/pssw_pkg.sv */
`default_nettype none

package pssw_pkg;

  typedef enum logic [1:0] {
    PSSW_PS_OFF,
    PSSW_PS_ON,
    PSSW_PS_SLEEP,
    PSSW_PS_BACKUP
  } pssw_ps_e;

  typedef enum logic [2:0] {
    PSSW_R_NONE,
    PSSW_R_CTRL,
    PSSW_R_KEY,
    PSSW_R_OFFSRC,
    PSSW_R_STS1,
    PSSW_R_STS2,
    PSSW_R_MSK1,
    PSSW_R_MSK2
  } pssw_reg_e;

  typedef struct packed {
    logic on_req;
    logic off_req;
  } pssw_req_s;

  typedef struct packed {
    logic [1:0] sec_act;
    logic [1:0] prim_act;
    logic [1:0] hold_to;
  } pssw_cfg_s;

endpackage

`default_nettype wire

/* File: verification/pssw_switch_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Push switch to ground, pulled up
// ****
module pssw_switch_model (
  input wire logic press,
  output logic switch_n
);
  assign switch_n = press ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* File: verification/pssw_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pssw_regs.svh"
// ****
// Port checks
// ****
module pssw_chk #(
  parameter int unsigned DEBOUNCE_CYCLES = `PSSW_DEBOUNCE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic switch_n,
  input wire pssw_pkg::pssw_ps_e ps_state,
  input wire pssw_pkg::pssw_req_s sw_req,
  input wire logic on_state_ind,
  input wire logic sleep_state_ind,
  input wire logic power_state_primary_irq,
  input wire logic switch_primary_irq
);
  import pssw_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Consecutive cycles the switch has read released
  logic [31:0] high_run;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_run <= 32'h0;
    end else if (switch_n) begin
      high_run <= high_run + 32'h1;
    end else begin
      high_run <= 32'h0;
    end
  end
  on_ind_a: assert property (1 |=> on_state_ind ==
    ($past(ps_state) == PSSW_PS_ON)) else $error("on indication wrong");
  sleep_ind_a: assert property (1 |=> sleep_state_ind ==
    ($past(ps_state) == PSSW_PS_SLEEP)) else $error("sleep ind wrong");
  ind_excl_a: assert property (!(on_state_ind && sleep_state_ind))
    else $error("both indications high");
  req_pulse_a: assert property (sw_req != 2'b00 |=> sw_req == 2'b00)
    else $error("request longer than a cycle");
  req_cause_a: assert property (sw_req != 2'b00 |->
    high_run <= DEBOUNCE_CYCLES + 1) else $error("request without press");
  sw_sticky_a: assert property (switch_primary_irq && !psel &&
    !$past(psel) |=> switch_primary_irq) else $error("switch irq dropped");
  ps_sticky_a: assert property (power_state_primary_irq && !psel &&
    !$past(psel) |=> power_state_primary_irq) else $error("ps irq dropped");
  ready_time_a: assert property (psel && !penable |-> ##2 pready)
    else $error("ready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready too long");
  ready_cause_a: assert property (pready |-> $past(psel) && $past(penable))
    else $error("ready without access");
  cover property (sw_req.off_req);
  cover property (switch_primary_irq);
  cover property (power_state_primary_irq);
endmodule
bind pssw_top pssw_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES))
  pssw_chk_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .switch_n(switch_n),
  .ps_state(ps_state), .sw_req(sw_req), .on_state_ind(on_state_ind),
  .sleep_state_ind(sleep_state_ind),
  .power_state_primary_irq(power_state_primary_irq),
  .switch_primary_irq(switch_primary_irq));
`default_nettype wire

/* File: verification/pssw_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pssw_top_tb;
  import pssw_pkg::*;
  localparam int HU = 50;
  localparam int DB = 4;
  localparam logic [15:0] KEY = 16'h3c5a; // Arbitrary value
  logic pclk, presetn, psel, penable, pwrite, por_ind, press, switch_n;
  logic [31:0] paddr, pwdata, prdata, q, seed;
  logic pready, pslverr, err, on_ind, slp_ind, ps_irq, sw_irq, irq;
  logic [1:0] pa, sa;
  logic [2:0] mk, fl;
  pssw_ps_e ps_state, prev;
  pssw_req_s sw_req;
  pssw_req_s ev[$];
  int t[$];
  int n_mismatch, samples_checked, lim, n;
  pssw_top #(.HOLD_UNIT_CYCLES(HU), .DEBOUNCE_CYCLES(DB), .USER_KEY(KEY))
    pssw_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ps_state(ps_state), .por_ind(por_ind), .switch_n(switch_n),
    .sw_req(sw_req), .on_state_ind(on_ind), .sleep_state_ind(slp_ind),
    .power_state_primary_irq(ps_irq), .switch_primary_irq(sw_irq),
    .irq(irq));
  pssw_switch_model pssw_switch_model_inst (.press(press),
    .switch_n(switch_n));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] nx(logic [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [2:0] psf(pssw_ps_e a, pssw_ps_e b, logic p);
    psf = {p, a != b && (b == PSSW_PS_SLEEP || b == PSSW_PS_OFF),
      a != b && b == PSSW_PS_ON};
  endfunction
  function automatic pssw_req_s rq(logic [1:0] c);
    rq = (c == 2'h1) ? 2'b10 : 2'b01;
  endfunction
  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a,
    input logic [31:0] d);
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {14'h0, a, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      test_done();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    {psel, penable, pwrite, por_ind, press, presetn} = 6'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    ps_state = PSSW_PS_OFF;
    n_mismatch = 0;
    samples_checked = 0;
    seed = 32'h8c97;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(16'h4005, 32'h108);
    rd(16'h401a, 32'h7);
    rd(16'h4019, 32'h1000);
    rd(16'h4003, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, 16'h4005, 32'h12);
    rd(16'h4005, 32'h108);
    apb(1'b1, 16'h4008, {16'h0, KEY});
    apb(1'b1, 16'h4019, 32'h0);
    for (int i = 0; i < 12; i++) begin
      seed = nx(seed);
      mk = seed[7:5];
      apb(1'b1, 16'h401a, {29'h0, mk});
      prev = ps_state;
      ps_state <= pssw_ps_e'(seed[1:0]);
      por_ind <= seed[4];
      fl = psf(prev, pssw_ps_e'(seed[1:0]), seed[4]);
      repeat (3) @(posedge pclk);
      por_ind <= 1'b0;
      chk(ps_irq, |(fl & ~mk));
      chk(on_ind, pssw_ps_e'(seed[1:0]) == PSSW_PS_ON);
      chk(slp_ind, pssw_ps_e'(seed[1:0]) == PSSW_PS_SLEEP);
      chk(irq, |(fl & ~mk));
      apb(1'b1, 16'h4012, 32'h0);
      rd(16'h4012, fl);
      apb(1'b1, 16'h4012, 32'h7);
      rd(16'h4012, 32'h0);
    end
    ps_state <= PSSW_PS_ON;
    for (int k = 0; k < 4; k++) begin
      seed = nx(seed);
      pa = 2'(seed[1:0] % 2'd3);
      sa = 2'(seed[3:2] % 2'd3);
      lim = HU << k;
      apb(1'b1, 16'h4005, {22'h0, sa, 2'h0, pa, 2'h0, 2'(k)});
      apb(1'b1, 16'h4011, 32'h1000);
      ev.delete();
      t.delete();
      press <= 1'b1;
      for (int i = 0; i < 2 * lim + 40; i++) begin
        @(posedge pclk);
        if (sw_req != 2'b00) begin
          ev.push_back(sw_req);
          t.push_back(i);
        end
      end
      n = ev.size();
      chk(n, 32'((pa != 0) + (sa != 0) + 1));
      chk(ev[n - 1], 2'b01);
      if (pa != 0) chk(ev[0], rq(pa));
      if (sa != 0) chk(ev[n - 2], rq(sa));
      if (sa != 0) chk(t[n - 1] - t[n - 2], lim);
      if (pa != 0 && sa == 0) chk(t[1] - t[0], 2 * lim);
      rd(16'h4005, {22'h0, sa, 2'h0, pa, 2'h0, 2'(k)});
      rd(16'h4011, 32'h1000);
      chk(sw_irq, 1'b1);
      apb(1'b1, 16'h4011, 32'h0);
      rd(16'h4011, 32'h1000);
      apb(1'b1, 16'h4011, 32'h1000);
      rd(16'h4011, 32'h0);
      press <= 1'b0;
      repeat (DB + 10) @(posedge pclk);
      rd(16'h4005, {22'h0, sa, 2'h0, pa, 2'h0, 2'(k)} | 32'h8);
      rd(16'h4011, 32'h1000);
      apb(1'b1, 16'h4011, 32'h1000);
    end
    ps_state <= PSSW_PS_OFF;
    repeat (3) @(posedge pclk);
    rd(16'h4009, 32'h10);
    ps_state <= PSSW_PS_ON;
    repeat (3) @(posedge pclk);
    ps_state <= PSSW_PS_OFF;
    repeat (3) @(posedge pclk);
    rd(16'h4009, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
